//--- pkg/adc_mode_pkg.sv
package adc_mode_pkg;

    // register offsets on the byte-wide register port
    localparam logic [7:0] CONFIG_OFFSET      = 8'h00;
    localparam logic [7:0] ACCUM_OFFSET       = 8'h01;
    localparam logic [7:0] TRACKING_OFFSET    = 8'h02;
    localparam logic [7:0] CONTROL_OFFSET     = 8'h03;
    localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h04;
    localparam logic [7:0] RESULT_LOW_OFFSET  = 8'h05;
    localparam logic [7:0] STATUS_OFFSET      = 8'h06;

    // converter_config_reg fields
    localparam int GAIN_BIT  = 0;
    localparam int EIGHT_BIT = 1;
    // accumulator_config_reg fields
    localparam int TWELVE_BIT    = 0;
    localparam int BURST_BIT     = 1;
    localparam int REPEAT_LSB    = 2;
    localparam int REPEAT_W      = 3;
    // tracking_config_reg field
    localparam int SAMPLE_SEL_BIT = 0;
    // control register field
    localparam int START_BIT = 0;
    // status register fields
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 1;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // converter geometry
    localparam int CODE_W      = 10;
    localparam int ACC_W       = 16;
    localparam int CNT_W       = 7;
    localparam int EIGHT_LAST  = 2;
    localparam int SETS_OF     = 4;
    localparam logic [CODE_W-1:0] CODE_MSB = 10'h200;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRACK_TIME_NS = 300;
    localparam int TRACK_CYCLES  = (TRACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAR_DIV       = 4;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TRACK   = 3'b001,
        ST_CONVERT = 3'b011,
        ST_ACCUM   = 3'b010
    } conv_state_t;

endpackage

//--- rtl/rate_divider.sv
`timescale 1ns/1ps
module rate_divider #(
    parameter int DIV = 4
) (
    input  wire logic clk,
    input  wire logic resetn,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    initial begin
        if (DIV < 2) begin
            $error("rate_divider needs DIV of at least 2");
        end
    end

    logic [CW-1:0] count;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            tick  <= (count == LAST);
            count <= (count == LAST) ? '0 : count + CW'(1);
        end
    end
endmodule // rate_divider

//--- rtl/adc_resolution_mode_control.sv
`timescale 1ns/1ps
module adc_resolution_mode_control #(
    parameter int TRACK_CYC = adc_mode_pkg::TRACK_CYCLES,
    parameter int SAR_DIV   = adc_mode_pkg::SAR_DIV
) (
    input  wire logic                              clk,
    input  wire logic                              resetn,
    input  wire logic [7:0]                        addr,
    input  wire logic [7:0]                        wdata,
    input  wire logic                              wr,
    input  wire logic                              rd,
    output logic      [7:0]                        rdata,
    input  wire logic                              start_pin,
    input  wire logic                              start_timer,
    input  wire logic                              comp_in,
    output logic      [adc_mode_pkg::CODE_W-1:0]   dac_code,
    output logic      [1:0]                        dac_rotation,
    output logic      [1:0]                        ref_select,
    output logic                                   track_en,
    output logic                                   gain_half,
    output logic                                   busy
);
    localparam int TW = 8;

    initial begin
        // a start must show at least two tracking cycles on track_en
        if (TRACK_CYC < 2 || TRACK_CYC > 255) begin
            $error("TRACK_CYC must lie in 2..255");
        end
        if (SAR_DIV < 2) begin
            $error("SAR_DIV must be at least 2");
        end
    end

    typedef struct packed {
        adc_mode_pkg::conv_state_t          st;
        logic                               gain;
        logic                               eight;
        logic                               twelve;
        logic                               burst;
        logic [adc_mode_pkg::REPEAT_W-1:0]  rpt;
        logic                               smpl;
        logic [adc_mode_pkg::ACC_W-1:0]     acc;
        logic [adc_mode_pkg::ACC_W-1:0]     result;
        logic                               res_eight;
        logic [adc_mode_pkg::CODE_W-1:0]    code;
        logic [3:0]                         bitn;
        logic                               phase;
        logic [adc_mode_pkg::CNT_W-1:0]     conv_cnt;
        logic [adc_mode_pkg::CNT_W-1:0]     total;
        logic                               set_eight;
        logic                               set_twelve;
        logic                               set_hold;
        logic [TW-1:0]                      trk_cnt;
        logic [7:0]                         rdata;
        logic                               done;
        logic [1:0]                         comp_sync;
        logic [1:0]                         pin_sync;
        logic                               pin_prev;
    } state_t;

    state_t s;
    state_t next_s;
    logic   sar_tick;

    rate_divider #(
        .DIV (SAR_DIV)
    ) u_sar_rate (
        .clk    (clk),
        .resetn (resetn),
        .tick   (sar_tick)
    );

    // conversions per set from the repeat code: 0 means one, k means 2 << k, capped at 64
    // power-of-two counts, so every count from four up is a multiple of four
    function automatic logic [adc_mode_pkg::CNT_W-1:0] repeat_total(
        input logic [adc_mode_pkg::REPEAT_W-1:0] code
    );
        logic [adc_mode_pkg::CNT_W-1:0] v;
        v = 7'h01;
        if (code >= 3'h6) begin
            v = 7'h40;
        end else if (code != 3'h0) begin
            v = 7'h02 << code;
        end
        return v;
    endfunction

    logic                            sw_start;
    logic                            pin_edge;
    logic                            go;
    logic [adc_mode_pkg::CNT_W-1:0]  cfg_total;
    logic                            cfg_twelve;
    logic                            last_conv;
    logic                            cmp_high;

    assign sw_start = wr && (addr == adc_mode_pkg::CONTROL_OFFSET)
                      && wdata[adc_mode_pkg::START_BIT];
    assign pin_edge = s.pin_sync[1] && !s.pin_prev;
    assign go        = sw_start || pin_edge || start_timer;
    assign cfg_total = s.eight ? 7'h01 : (s.burst ? repeat_total(s.rpt) : 7'h01);
    // twelve-bit only with burst and four or more
    assign cfg_twelve = s.twelve && s.burst && !s.eight && (cfg_total >= 7'(adc_mode_pkg::SETS_OF));
    assign last_conv  = (s.conv_cnt + 7'h01) == s.total;
    assign cmp_high   = s.comp_sync[1];

    always_comb begin
        next_s = s;
        next_s.done      = 1'b0;
        next_s.comp_sync = {s.comp_sync[0], comp_in};
        next_s.pin_sync  = {s.pin_sync[0], start_pin};
        next_s.pin_prev  = s.pin_sync[1];

        if (wr) begin
            unique case (addr)
                adc_mode_pkg::CONFIG_OFFSET: begin
                    next_s.gain  = wdata[adc_mode_pkg::GAIN_BIT];
                    next_s.eight = wdata[adc_mode_pkg::EIGHT_BIT];
                end
                adc_mode_pkg::ACCUM_OFFSET: begin
                    next_s.twelve = wdata[adc_mode_pkg::TWELVE_BIT];
                    next_s.burst  = wdata[adc_mode_pkg::BURST_BIT];
                    next_s.rpt    = wdata[adc_mode_pkg::REPEAT_LSB +: adc_mode_pkg::REPEAT_W];
                end
                adc_mode_pkg::TRACKING_OFFSET: begin
                    next_s.smpl = wdata[adc_mode_pkg::SAMPLE_SEL_BIT];
                end
                default: begin
                end
            endcase
        end

        next_s.rdata = adc_mode_pkg::RESET_BYTE;
        if (rd) begin
            unique case (addr)
                adc_mode_pkg::CONFIG_OFFSET: begin
                    next_s.rdata[adc_mode_pkg::GAIN_BIT]  = s.gain;
                    next_s.rdata[adc_mode_pkg::EIGHT_BIT] = s.eight;
                end
                adc_mode_pkg::ACCUM_OFFSET: begin
                    next_s.rdata[adc_mode_pkg::TWELVE_BIT] = s.twelve;
                    next_s.rdata[adc_mode_pkg::BURST_BIT]  = s.burst;
                    next_s.rdata[adc_mode_pkg::REPEAT_LSB +: adc_mode_pkg::REPEAT_W] = s.rpt;
                end
                adc_mode_pkg::TRACKING_OFFSET: begin
                    next_s.rdata[adc_mode_pkg::SAMPLE_SEL_BIT] = s.smpl;
                end
                adc_mode_pkg::RESULT_HIGH_OFFSET: begin
                    next_s.rdata = s.res_eight ? s.result[9:2] : s.result[15:8];
                end
                adc_mode_pkg::RESULT_LOW_OFFSET: begin
                    // low byte zero in eight-bit mode
                    next_s.rdata = s.res_eight ? adc_mode_pkg::RESET_BYTE : s.result[7:0];
                end
                adc_mode_pkg::STATUS_OFFSET: begin
                    next_s.rdata[adc_mode_pkg::BUSY_BIT] = (s.st != adc_mode_pkg::ST_IDLE);
                    next_s.rdata[adc_mode_pkg::DONE_BIT] = s.done;
                end
                default: begin
                end
            endcase
        end

        unique case (s.st)
            adc_mode_pkg::ST_IDLE: begin
                if (go) begin
                    next_s.acc        = '0;
                    next_s.conv_cnt   = '0;
                    next_s.total      = cfg_total;
                    next_s.set_eight  = s.eight;
                    next_s.set_twelve = cfg_twelve;
                    next_s.set_hold   = s.smpl && cfg_twelve;
                    next_s.trk_cnt    = '0;
                    next_s.st         = adc_mode_pkg::ST_TRACK;
                end
            end
            adc_mode_pkg::ST_TRACK: begin
                next_s.trk_cnt = s.trk_cnt + TW'(1);
                if (s.trk_cnt == TW'(TRACK_CYC - 1)) begin
                    next_s.code  = adc_mode_pkg::CODE_MSB;
                    next_s.bitn  = 4'(adc_mode_pkg::CODE_W - 1);
                    next_s.phase = 1'b0;
                    next_s.st    = adc_mode_pkg::ST_CONVERT;
                end
            end
            adc_mode_pkg::ST_CONVERT: begin
                if (sar_tick) begin
                    // phase 0 lets the comparator settle on the trial code
                    next_s.phase = !s.phase;
                    if (s.phase) begin
                        if (!cmp_high) begin
                            next_s.code[s.bitn] = 1'b0;
                        end
                        if (s.bitn == (s.set_eight ? 4'(adc_mode_pkg::EIGHT_LAST) : 4'h0)) begin
                            next_s.st = adc_mode_pkg::ST_ACCUM;
                        end else begin
                            next_s.code[s.bitn - 4'h1] = 1'b1;
                            next_s.bitn = s.bitn - 4'h1;
                        end
                    end
                end
            end
            adc_mode_pkg::ST_ACCUM: begin
                // plain sum without saturation, four full codes peak at 4092
                next_s.acc      = s.acc + adc_mode_pkg::ACC_W'(s.code);
                next_s.conv_cnt = s.conv_cnt + 7'h01;
                next_s.trk_cnt  = '0;
                next_s.code     = adc_mode_pkg::CODE_MSB;
                next_s.bitn     = 4'(adc_mode_pkg::CODE_W - 1);
                next_s.phase    = 1'b0;
                if (last_conv) begin
                    // result only after the last conversion
                    next_s.result    = s.acc + adc_mode_pkg::ACC_W'(s.code);
                    next_s.res_eight = s.set_eight;
                    next_s.done      = 1'b1;
                    next_s.st        = adc_mode_pkg::ST_IDLE;
                end else if (s.set_hold) begin
                    next_s.st = adc_mode_pkg::ST_CONVERT;
                end else begin
                    next_s.st = adc_mode_pkg::ST_TRACK;
                end
            end
            default: begin
                next_s.st = adc_mode_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata    = s.rdata;
    assign dac_code = s.code;
    // rotate DAC elements per conversion of a twelve-bit set, held at 0 otherwise
    assign dac_rotation = s.set_twelve ? s.conv_cnt[1:0] : 2'h0;
    assign ref_select   = s.set_twelve ? s.conv_cnt[1:0] : 2'h0;
    assign track_en     = (s.st == adc_mode_pkg::ST_TRACK);
    assign gain_half    = s.gain;
    assign busy         = (s.st != adc_mode_pkg::ST_IDLE);

    a_gain_follows_write: assert property (
        @(posedge clk) disable iff (!resetn)
        wr && addr == adc_mode_pkg::CONFIG_OFFSET
        |=> gain_half == $past(wdata[adc_mode_pkg::GAIN_BIT]))
        else $error("gain output does not follow the configuration write");

    a_eight_lsb_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_ACCUM && s.set_eight |-> s.code[1:0] == 2'b00)
        else $error("eight-bit conversion resolved a low bit");

    a_low_byte_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        rd && addr == adc_mode_pkg::RESULT_LOW_OFFSET && s.res_eight |=> rdata == 8'h00)
        else $error("low result byte not zero in eight-bit mode");

    a_ref_steps_up: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_ACCUM && s.set_twelve && !last_conv
        |=> ref_select == $past(ref_select) + 2'h1)
        else $error("reference did not advance between conversions");

    a_rotation_per_conv: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_ACCUM && s.set_twelve && !last_conv
        |=> dac_rotation != $past(dac_rotation))
        else $error("DAC arrangement not changed for the next conversion");

    a_start_launches: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_IDLE && (pin_edge || start_timer)
        |=> track_en ##1 track_en)
        else $error("start source did not launch a set");

    a_sum_bounded: assert property (
        @(posedge clk) disable iff (!resetn)
        17'(s.acc) <= 17'(s.conv_cnt) * 17'h0_3FF)
        else $error("accumulated sum exceeds conversions times full scale");

    a_hold_no_track: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_ACCUM && s.set_hold && !last_conv
        |=> !track_en [*2])
        else $error("input tracked again while holding the sample");

    a_retrack_each: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_ACCUM && !s.set_hold && !last_conv |=> track_en)
        else $error("input not tracked before the next conversion");

    a_acc_cleared: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_IDLE && go |=> s.acc == '0 && s.conv_cnt == '0)
        else $error("accumulator not cleared at set start");

    a_set_multiple: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st != adc_mode_pkg::ST_IDLE && s.set_twelve |-> s.total[1:0] == 2'b00)
        else $error("twelve-bit set length not a multiple of four");

    a_result_on_store: assert property (
        @(posedge clk) disable iff (!resetn)
        $changed(s.result)
        |-> $past(s.st) == adc_mode_pkg::ST_ACCUM && $past(last_conv))
        else $error("result changed outside the last accumulate step");

    a_twelve_needs_burst: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_IDLE && go && s.twelve && !s.burst
        |=> !s.set_twelve)
        else $error("twelve-bit set started without burst mode");

    a_eight_single: assert property (
        @(posedge clk) disable iff (!resetn)
        s.st == adc_mode_pkg::ST_TRACK && s.set_eight |-> s.total == 7'h01)
        else $error("eight-bit set runs more than one conversion");

endmodule // adc_resolution_mode_control

//--- bench/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
    input  wire logic                            clk,
    input  wire logic                            resetn,
    input  wire logic [9:0]                      level,
    input  wire logic [adc_mode_pkg::CODE_W-1:0] dac_code,
    input  wire logic                            track_en,
    input  wire logic                            gain_half,
    output logic                                 comp_in
);
    logic [9:0] held;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            held <= 10'h000;
        end else if (track_en) begin
            held <= gain_half ? {1'b0, level[9:1]} : level;
        end
    end

    // answers at once; the design's own synchroniser adds the lag
    assign comp_in = (held >= dac_code);
endmodule // analog_front_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                            clk;
    logic                            resetn;
    logic [7:0]                      addr;
    logic [7:0]                      wdata;
    logic                            wr;
    logic                            rd;
    logic [7:0]                      rdata;
    logic                            start_pin;
    logic                            start_timer;
    logic                            comp_in;
    logic [adc_mode_pkg::CODE_W-1:0] dac_code;
    logic [1:0]                      dac_rotation;
    logic [1:0]                      ref_select;
    logic                            track_en;
    logic                            gain_half;
    logic                            busy;
    logic [9:0]                      level;
    logic [15:0]                     res;
    logic [3:0]                      mask;
    logic [3:0]                      ref_mask;
    int                              fails;
    int                              total_checks;
    int                              cyc;
    int                              rises;

    // short track and sar timing keep the run brief
    adc_resolution_mode_control #(.TRACK_CYC(2), .SAR_DIV(2)) u_adc_resolution_mode_control (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .start_pin(start_pin), .start_timer(start_timer), .comp_in(comp_in),
        .dac_code(dac_code), .dac_rotation(dac_rotation), .ref_select(ref_select),
        .track_en(track_en), .gain_half(gain_half), .busy(busy));

    analog_front_model u_front (
        .clk(clk), .resetn(resetn), .level(level), .dac_code(dac_code), .track_en(track_en),
        .gain_half(gain_half), .comp_in(comp_in));

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic timed_out(input string what);
        $display("CHECK FAILED %s expected done seen timeout", what);
        fails++;
        summarize();
    endtask

    // src 0 control write, 1 on-clock pulse, 2 external pin
    task automatic run_set(input int src, input logic extra);
        logic [7:0] hi;
        logic [7:0] lo;
        logic       prev;
        int         n;
        prev     = 1'b0;
        mask     = 4'h0;
        ref_mask = 4'h0;
        cyc      = 0;
        rises    = 0;
        n        = 0;
        if (src == 0) begin
            wr_reg(adc_mode_pkg::CONTROL_OFFSET, 8'h01);
        end else begin
            @(posedge clk);
            start_timer <= (src == 1);
            start_pin   <= (src == 2);
        end
        // start strobes drop at a rising edge, one cycle after they rose
        while (busy !== 1'b1) begin
            @(posedge clk);
            start_timer <= 1'b0;
            start_pin   <= 1'b0;
            #1;
            n++;
            if (n > 20) timed_out("set_start");
        end
        while (busy === 1'b1) begin
            if (track_en === 1'b1 && !prev) rises++;
            prev = track_en;
            mask[dac_rotation]   = 1'b1;
            ref_mask[ref_select] = 1'b1;
            @(posedge clk);
            start_timer <= (cyc == 2) && extra;
            #1;
            cyc++;
            if (cyc > 5000) timed_out("set_end");
        end
        rd_reg(adc_mode_pkg::RESULT_HIGH_OFFSET, hi);
        rd_reg(adc_mode_pkg::RESULT_LOW_OFFSET, lo);
        res = {hi, lo};
    endtask

    task automatic test_reset();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rd_reg(8'(a), d);
            chk("reset_read", 16'h0000, {8'h00, d});
        end
        chk("reset_dac_code", 16'h0000, {6'h00, dac_code});
        chk("reset_pins", 16'h0000,
            {9'h000, busy, track_en, gain_half, dac_rotation, ref_select});
        wr_reg(8'h07, 8'hFF);
        rd_reg(8'h07, d);
        chk("unmapped_read", 16'h0000, {8'h00, d});
        $display("test reset done");
    endtask

    task automatic test_gain();
        wr_reg(adc_mode_pkg::CONFIG_OFFSET, 8'h01);
        @(posedge clk);
        #1;
        chk("gain_half_on", 16'h0001, {15'h0000, gain_half});
        level = 10'h258;
        run_set(0, 1'b0);
        chk("half_gain_result", 16'h012C, res);
        wr_reg(adc_mode_pkg::CONFIG_OFFSET, 8'h00);
        @(posedge clk);
        #1;
        chk("gain_half_off", 16'h0000, {15'h0000, gain_half});
        $display("test gain done");
    endtask

    task automatic test_ten_eight();
        int c10;
        level = 10'h2AB;
        run_set(1, 1'b0);
        c10 = cyc;
        chk("ten_bit_result", 16'h02AB, res);
        wr_reg(adc_mode_pkg::CONFIG_OFFSET, 8'h02);
        run_set(2, 1'b0);
        chk("eight_bit_high", 16'h00AA, {8'h00, res[15:8]});
        chk("eight_bit_low", 16'h0000, {8'h00, res[7:0]});
        chk("eight_bit_faster", 16'h0001, {15'h0000, cyc < c10});
        wr_reg(adc_mode_pkg::CONFIG_OFFSET, 8'h00);
        $display("test ten and eight bit done");
    endtask

    task automatic test_twelve();
        wr_reg(adc_mode_pkg::ACCUM_OFFSET, 8'h07);
        wr_reg(adc_mode_pkg::TRACKING_OFFSET, 8'h01);
        level = 10'h3FF;
        run_set(1, 1'b0);
        chk("twelve_max", 16'h0FFC, res);
        chk("track_once", 16'h0001, 16'(rises));
        chk("rotations_seen", 16'h000F, {12'h000, mask});
        chk("references_seen", 16'h000F, {12'h000, ref_mask});
        wr_reg(adc_mode_pkg::TRACKING_OFFSET, 8'h00);
        level = 10'h155;
        run_set(2, 1'b0);
        chk("sum_cleared_per_set", 16'h0554, res);
        chk("track_each", 16'h0004, 16'(rises));
        $display("test twelve bit done");
    endtask

    task automatic test_repeat();
        wr_reg(adc_mode_pkg::ACCUM_OFFSET, 8'h0F);
        level = 10'h3FF;
        run_set(0, 1'b1);
        chk("sum_of_sixteen", 16'h3FF0, res);
        repeat (10) @(posedge clk);
        #1;
        chk("start_while_busy_ignored", 16'h0000, {15'h0000, busy});
        wr_reg(adc_mode_pkg::ACCUM_OFFSET, 8'h01);
        level = 10'h155;
        run_set(1, 1'b0);
        chk("twelve_needs_burst", 16'h0155, res);
        chk("plain_no_rotation", 16'h0001, {12'h000, mask});
        $display("test repeat done");
    endtask

    // reset in the middle of a set must abort it and clear every register
    task automatic test_mid_reset();
        logic [7:0] d;
        wr_reg(adc_mode_pkg::CONFIG_OFFSET, 8'h01);
        @(posedge clk);
        start_timer <= 1'b1;
        @(posedge clk);
        start_timer <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("busy_before_reset", 16'h0001, {15'h0000, busy});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("reset_mid_pins", 16'h0000, {13'h0000, busy, track_en, gain_half});
        rd_reg(adc_mode_pkg::CONFIG_OFFSET, d);
        chk("reset_mid_config", 16'h0000, {8'h00, d});
        rd_reg(adc_mode_pkg::RESULT_LOW_OFFSET, d);
        chk("reset_mid_result", 16'h0000, {8'h00, d});
        $display("test mid reset done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        resetn       = 1'b0;
        addr         = 8'h00;
        wdata        = 8'h00;
        wr           = 1'b0;
        rd           = 1'b0;
        start_pin    = 1'b0;
        start_timer  = 1'b0;
        level        = 10'h000;
        fails        = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        test_reset();
        test_gain();
        test_ten_eight();
        test_twelve();
        test_repeat();
        test_mid_reset();
        summarize();
    end
endmodule // testbench
